/* File: config_pin_control_defs.vh */
// Constants for the configuration pin control block
// Behaviour
// - Completion pin driven low from power-up through configuration.
// - Completion pin released only after error-free load and wakeup start.
// - A high completion pin level means configuration has finished.
// - Wakeup stalls while the completion pin is held low outside.
// - All modes but JTAG run synchronously to the configuration clock pin.
// - Slave modes take the configuration clock as input and capture with it.
// - Master SPI drives the configuration clock pin as an output.
// - Configuration clock pin is high impedance when no clock is needed.
// - User pull-ups enabled until user mode when pull-up select reads 0, disabled on 1 and in user mode.
// - Master SPI may use the external master clock input instead.
// - Multiplexed pins unused outside their modes and during initialisation.
// - Master SPI x1, x2, x4 drive the flash select low active.
// - Master SPI x8 also drives the second flash select low active.
// - Slave parallel interface enabled only while parallel select is low.
// - Multiplexed pins released to user logic once configuration completes.
// - Completion and clock pins get weak pull-up or float after configuring.
// - Reset pin fall clears configuration; next rise starts a new one.
`ifndef CONFIG_PIN_CONTROL_DEFS_VH
`define CONFIG_PIN_CONTROL_DEFS_VH

// Boot mode encodings
`define MODE_JTAG      3'h0
`define MODE_SPI_X1    3'h1
`define MODE_SPI_X2    3'h2
`define MODE_SPI_X4    3'h3
`define MODE_SPI_X8    3'h4
`define MODE_SLV_SER   3'h5
`define MODE_SLV_PAR   3'h6

// Sequence states
`define ST_INIT        3'h0
`define ST_CLEAR       3'h1
`define ST_LOAD        3'h2
`define ST_WAKE        3'h3
`define ST_USER        3'h4

// Master clock half period in system clock cycles
`define CCLK_HALF      8'h04

`endif

/* File: sync_two_stage.v */
// Two flip-flop synchroniser for pin-level inputs
module sync_two_stage #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // Asynchronous inputs and their synchronised copies
  input  wire [WIDTH-1:0] async_in,
  input  wire [WIDTH-1:0] reset_value,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // First stage is read only by the second stage
  always @(posedge clk) begin
    if (sys_rst) begin
      stage1   <= reset_value;
      sync_out <= reset_value;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // sync_two_stage

/* File: config_pin_control.v */
// Configuration pin control: completion, clock, selects and pull-ups
`include "config_pin_control_defs.vh"

module config_pin_control #(
  parameter [7:0] CCLK_HALF = `CCLK_HALF
) (
  // Clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // Boot mode and user choices
  input  wire [2:0] boot_mode,
  input  wire       ext_clk_request,
  input  wire       post_cfg_pullup,
  // Engine status, same clock domain
  input  wire       load_ok,
  input  wire       load_error,
  // Configuration pins, sampled
  input  wire       config_reset_n,
  input  wire       done_in,
  input  wire       cfg_clk_in,
  input  wire       external_master_clock_in,
  input  wire       pullup_select,
  input  wire       parallel_select_n,
  input  wire       read_write_select,
  // Completion pin drive, open drain
  output reg        done_out,
  output reg        done_oe_n,
  output reg        done_pull_en,
  // Configuration clock pin drive
  output reg        cfg_clk_out,
  output reg        cfg_clk_oe_n,
  output reg        cfg_clk_pull_en,
  // Flash selects
  output reg        flash_select_n,
  output reg        flash_select_oe_n,
  output reg        second_flash_select_n,
  output reg        second_flash_select_oe_n,
  // Pin policy
  output reg        user_pullup_en,
  output reg        mux_pins_released,
  output reg        ext_clk_select,
  // Engine timing and control
  output reg        cfg_clk_tick,
  output reg        parallel_if_en,
  output reg        parallel_read,
  output reg        config_clear,
  output reg        config_start,
  // Status
  output reg        wakeup_stall,
  output reg        config_complete,
  output reg        config_fail,
  output reg [2:0]  phase
);

  localparam [2:0] ST_INIT  = `ST_INIT;
  localparam [2:0] ST_CLEAR = `ST_CLEAR;
  localparam [2:0] ST_LOAD  = `ST_LOAD;
  localparam [2:0] ST_WAKE  = `ST_WAKE;
  localparam [2:0] ST_USER  = `ST_USER;

  function is_master;
    input [2:0] m;
    begin
      is_master = (m == `MODE_SPI_X1) || (m == `MODE_SPI_X2) ||
                  (m == `MODE_SPI_X4) || (m == `MODE_SPI_X8);
    end
  endfunction

  function is_slave;
    input [2:0] m;
    begin
      is_slave = (m == `MODE_SLV_SER) || (m == `MODE_SLV_PAR);
    end
  endfunction

  // Synchronised pins
  wire [6:0] pins_sync;
  reg  [6:0] pins_last;

  sync_two_stage #(
    .WIDTH       (7)
  ) u_sync (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .async_in    ({config_reset_n, done_in, cfg_clk_in,
                   external_master_clock_in, pullup_select,
                   parallel_select_n, read_write_select}),
    .reset_value (7'h7f),
    .sync_out    (pins_sync)
  );

  wire rst_pin  = pins_sync[6];
  wire done_s   = pins_sync[5];
  wire cclk_s   = pins_sync[4];
  wire eclk_s   = pins_sync[3];
  wire pull_s   = pins_sync[2];
  wire psel_n_s = pins_sync[1];
  wire rw_s     = pins_sync[0];

  wire rst_fall  = pins_last[6] & ~rst_pin;
  wire rst_rise  = ~pins_last[6] & rst_pin;
  wire cclk_rise = ~pins_last[4] & cclk_s;
  wire eclk_rise = ~pins_last[3] & eclk_s;

  reg  [2:0] state;
  reg  [2:0] next_state;
  reg  [7:0] div_count;
  reg        div_clk;
  reg        load_failed;
  wire       master    = is_master(boot_mode);
  wire       slave     = is_slave(boot_mode);
  wire       loading   = (state == ST_LOAD);
  wire       in_user   = (state == ST_USER);
  wire       use_ext   = master & ext_clk_request & ~in_user;
  wire       div_rise  = loading & master & ~use_ext &
                         (div_count == CCLK_HALF - 8'h01) & ~div_clk;

  // Edge history of synchronised pins
  always @(posedge clk) begin
    if (sys_rst) begin
      pins_last <= 7'h7f;
    end else begin
      pins_last <= pins_sync;
    end
  end

  // Sequence
  always @* begin
    next_state = state;
    case (state)
      ST_INIT: begin
        next_state = ST_LOAD;
      end
      ST_CLEAR: begin
        if (rst_rise) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        // A load that saw an error never reaches wakeup
        if (load_ok & ~load_error & ~load_failed) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (done_s) begin
          next_state = ST_USER;
        end
      end
      ST_USER: begin
        next_state = ST_USER;
      end
      default: begin
        next_state = ST_INIT;
      end
    endcase
    // Reset pin fall wins over every other move
    if (rst_fall) begin
      next_state = ST_CLEAR;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  // Error tracking for the current load
  always @(posedge clk) begin
    if (sys_rst) begin
      load_failed <= 1'b0;
    end else if (state != ST_LOAD) begin
      load_failed <= 1'b0;
    end else if (load_error) begin
      load_failed <= 1'b1;
    end
  end

  // Internal master clock divider
  always @(posedge clk) begin
    if (sys_rst) begin
      div_count <= 8'h00;
      div_clk   <= 1'b0;
    end else if (!(loading & master & ~use_ext)) begin
      div_count <= 8'h00;
      div_clk   <= 1'b0;
    end else if (div_count == CCLK_HALF - 8'h01) begin
      div_count <= 8'h00;
      div_clk   <= ~div_clk;
    end else begin
      div_count <= div_count + 8'h01;
    end
  end

  // Completion pin
  always @(posedge clk) begin
    if (sys_rst) begin
      done_out     <= 1'b0;
      done_oe_n    <= 1'b0;
      done_pull_en <= 1'b1;
    end else begin
      done_out  <= 1'b0;
      // Driven low until wakeup begins
      done_oe_n <= (next_state == ST_WAKE) ||
                   (next_state == ST_USER);
      // Pull-up kept while configuring, user choice afterwards
      if (next_state == ST_USER) begin
        done_pull_en <= post_cfg_pullup;
      end else begin
        done_pull_en <= 1'b1;
      end
    end
  end

  // Configuration clock pin
  always @(posedge clk) begin
    if (sys_rst) begin
      cfg_clk_out     <= 1'b1;
      cfg_clk_oe_n    <= 1'b1;
      cfg_clk_pull_en <= 1'b1;
    end else begin
      // Master with external source also feeds the flash from the pin
      if (use_ext) begin
        cfg_clk_out <= eclk_s;
      end else begin
        cfg_clk_out <= div_clk;
      end
      // Output only in master modes while loading; else input or hi-z
      cfg_clk_oe_n <= ~(loading & master);
      if (in_user) begin
        cfg_clk_pull_en <= post_cfg_pullup;
      end else begin
        cfg_clk_pull_en <= 1'b0;
      end
    end
  end

  // Engine clock tick; JTAG gets none
  always @(posedge clk) begin
    if (sys_rst) begin
      cfg_clk_tick   <= 1'b0;
      ext_clk_select <= 1'b0;
    end else begin
      ext_clk_select <= use_ext;
      if (!loading) begin
        cfg_clk_tick <= 1'b0;
      end else if (master) begin
        cfg_clk_tick <= use_ext ? eclk_rise : div_rise;
      end else if (boot_mode == `MODE_SLV_PAR) begin
        cfg_clk_tick <= cclk_rise & ~psel_n_s;
      end else if (slave) begin
        cfg_clk_tick <= cclk_rise;
      end else begin
        cfg_clk_tick <= 1'b0;
      end
    end
  end

  // Flash selects; high impedance outside master load
  always @(posedge clk) begin
    if (sys_rst) begin
      flash_select_n           <= 1'b1;
      flash_select_oe_n        <= 1'b1;
      second_flash_select_n    <= 1'b1;
      second_flash_select_oe_n <= 1'b1;
    end else begin
      flash_select_n    <= ~(loading & master);
      flash_select_oe_n <= ~(loading & master);
      second_flash_select_n <=
        ~(loading & (boot_mode == `MODE_SPI_X8));
      second_flash_select_oe_n <=
        ~(loading & (boot_mode == `MODE_SPI_X8));
    end
  end

  // Slave parallel interface
  always @(posedge clk) begin
    if (sys_rst) begin
      parallel_if_en <= 1'b0;
      parallel_read  <= 1'b0;
    end else begin
      // Select may come from host or from an upstream chain device
      parallel_if_en <= loading & (boot_mode == `MODE_SLV_PAR) &
                        ~psel_n_s;
      // Direction latched only while deselected
      if (psel_n_s) begin
        parallel_read <= rw_s;
      end
    end
  end

  // Pull-up policy and pin release
  always @(posedge clk) begin
    if (sys_rst) begin
      user_pullup_en    <= 1'b0;
      mux_pins_released <= 1'b0;
    end else begin
      // Policy holds until user mode; strap is read through the synchroniser
      if (!in_user) begin
        user_pullup_en <= ~pull_s;
      end else begin
        user_pullup_en <= 1'b0;
      end
      mux_pins_released <= (next_state == ST_USER);
    end
  end

  // Pulses and status
  always @(posedge clk) begin
    if (sys_rst) begin
      config_clear    <= 1'b0;
      config_start    <= 1'b0;
      wakeup_stall    <= 1'b0;
      config_complete <= 1'b0;
      config_fail     <= 1'b0;
      phase           <= ST_INIT;
    end else begin
      config_clear    <= rst_fall;
      config_start    <= (state == ST_CLEAR) & rst_rise;
      wakeup_stall    <= (state == ST_WAKE) & ~done_s;
      config_complete <= (next_state == ST_USER);
      config_fail     <= loading & (load_failed | load_error);
      phase           <= next_state;
    end
  end

endmodule // config_pin_control

/* File: config_pin_control_properties.sv */
// Assertions on the configuration pin control ports
module config_pin_control_properties (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Mode, choices and engine status
  input wire logic [2:0] boot_mode,
  input wire logic       ext_clk_request,
  input wire logic       post_cfg_pullup,
  input wire logic       load_ok,
  input wire logic       load_error,
  // Pins seen by the device
  input wire logic       done_in,
  input wire logic       config_reset_n,
  input wire logic       pullup_select,
  input wire logic       parallel_select_n,
  // Device outputs
  input wire logic       done_oe_n,
  input wire logic       done_pull_en,
  input wire logic       cfg_clk_oe_n,
  input wire logic       flash_select_n,
  input wire logic       second_flash_select_n,
  input wire logic       user_pullup_en,
  input wire logic       mux_pins_released,
  input wire logic       ext_clk_select,
  input wire logic       parallel_if_en,
  input wire logic       config_clear,
  input wire logic       wakeup_stall,
  input wire logic       config_complete,
  input wire logic       config_fail,
  input wire logic [2:0] phase
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire master = boot_mode >= 3'h1 && boot_mode <= 3'h4;
  a_done_driven: assert property (phase <= 3'h2 |-> !done_oe_n)
    else $error("done pin released early");
  a_release_ok: assert property (phase == 3'h2 && load_ok &&
    !load_error && !config_fail |=> done_oe_n && phase == 3'h3)
    else $error("done pin not released");
  a_wake_stall: assert property ((phase == 3'h3 && !done_in)[*4]
    |-> wakeup_stall) else $error("wakeup not stalled");
  a_wake_done: assert property ((phase == 3'h3 && done_in)[*3]
    |=> phase == 3'h4) else $error("user mode late");
  // Pin drives follow the state one edge late
  a_clk_dir: assert property ($past(phase) == 3'h2 &&
    phase == 3'h2 |-> cfg_clk_oe_n == !master)
    else $error("clock pin direction");
  a_flash_sel: assert property ($past(phase) == 3'h2 &&
    phase == 3'h2 |-> flash_select_n == !master &&
    second_flash_select_n == (boot_mode != 3'h4))
    else $error("flash select");
  a_pullup_policy: assert property ($stable(pullup_select)[*5] ##0
    phase < 3'h4 |-> user_pullup_en == !pullup_select)
    else $error("pull-up policy");
  a_par_off: assert property (parallel_select_n[*5] |->
    !parallel_if_en) else $error("parallel enable");
  a_ext_clk: assert property (ext_clk_select |->
    master && ext_clk_request) else $error("external clock");
  a_reset_clear: assert property ($fell(config_reset_n)
    |-> ##[2:5] config_clear) else $error("no clear");
  a_user_pins: assert property (config_complete |->
    mux_pins_released && done_pull_en == post_cfg_pullup)
    else $error("user pins");
  cover property (wakeup_stall);
  cover property (config_fail);
  cover property (phase == 3'h1);
endmodule // config_pin_control_properties
bind config_pin_control config_pin_control_properties
  u_config_pin_control_properties (.*);

/* File: config_far_side.sv */
// Far side: host clock, completion pin holder and pin resolution
module config_far_side (
  // Bench control
  input  wire logic run_clock,
  input  wire logic hold_low,
  // Device pin drives
  input  wire logic done_out,
  input  wire logic done_oe_n,
  input  wire logic cfg_clk_out,
  input  wire logic cfg_clk_oe_n,
  // Resolved pins
  output wire logic done_wire,
  output wire logic clk_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  logic host_clk = 1'b0;
  // Host clock stands low between frames
  always #80 host_clk = run_clock ? !host_clk : 1'b0;
  // External pull-up; holder may keep pin low
  assign done_wire = (done_oe_n | done_out) & !hold_low;
  assign clk_wire = cfg_clk_oe_n ? host_clk : cfg_clk_out;
endmodule // config_far_side

/* File: config_pin_control_bench.sv */
// Testbench for the configuration pin control block
`include "config_pin_control_defs.vh"
module config_pin_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, sys_rst = 1'b1, ext_clk_request = 1'b0, hold = 1'b0;
  logic post_cfg_pullup = 1'b0, load_ok = 1'b0, load_error = 1'b0;
  logic config_reset_n = 1'b1, pullup_select = 1'b1, run_clock = 1'b0;
  // Host picks the device; direction held static
  logic parallel_select_n = 1'b1, read_write_select = 1'b1;
  logic external_master_clock_in = 1'b0;
  logic [2:0] boot_mode = 3'h0;
  wire  done_in, cfg_clk_in, done_out, done_oe_n, done_pull_en, cfg_clk_out;
  wire  cfg_clk_oe_n, cfg_clk_pull_en, flash_select_n, flash_select_oe_n;
  wire  second_flash_select_n, second_flash_select_oe_n, user_pullup_en;
  wire  mux_pins_released, ext_clk_select, cfg_clk_tick, parallel_if_en;
  wire  parallel_read, config_clear, config_start, wakeup_stall;
  wire  config_complete, config_fail;
  wire  [2:0] phase;
  integer fails = 0, checked = 0, cyc = 0, seed = 32'h082d0b19, ticks, edges;
  logic clk_last;
  config_pin_control #(.CCLK_HALF(8'h02)) u_config_pin_control (.*);
  config_far_side u_config_far_side (.run_clock(run_clock), .hold_low(hold),
    .done_out(done_out), .done_oe_n(done_oe_n), .cfg_clk_out(cfg_clk_out),
    .cfg_clk_oe_n(cfg_clk_oe_n), .done_wire(done_in), .clk_wire(cfg_clk_in));
  always #10 clk = !clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    external_master_clock_in <= cyc[2];
    if (cyc == 20000) begin
      fails = fails + 1;
      final_report;
    end
  end
  function automatic logic is_master(input logic [2:0] m);
    return m >= `MODE_SPI_X1 && m <= `MODE_SPI_X8;
  endfunction
  task automatic check(input string what, input logic [2:0] seen, exp);
    checked = checked + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_phase(input logic [2:0] p);
    for (int n = 0; n < 12 && phase !== p; n++) @(negedge clk);
    check("phase", phase, p);
  endtask
  task final_report;
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic run(input logic [2:0] m, input logic err, hold_it);
    @(posedge clk) sys_rst <= 1'b1;
    boot_mode <= m;
    hold <= hold_it;
    pullup_select <= $random(seed);
    post_cfg_pullup <= $random(seed);
    ext_clk_request <= $random(seed);
    parallel_select_n <= $random(seed);
    run_clock <= m >= `MODE_SLV_SER;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(negedge clk);
    check("select", flash_select_n, !is_master(m));
    check("select 2", second_flash_select_n, m != `MODE_SPI_X8);
    check("pulls", user_pullup_en, !pullup_select);
    check("par en", parallel_if_en, m == 3'h6 && !parallel_select_n);
    check("ext clk", ext_clk_select, is_master(m) && ext_clk_request);
    check("select oe", flash_select_oe_n, !is_master(m));
    check("select 2 oe", second_flash_select_oe_n, m != `MODE_SPI_X8);
    check("fail", config_fail, 1'b0);
    check("rw", parallel_read, read_write_select);
    check("done drive", done_out, 1'b0);
    ticks = 0;
    edges = 0;
    clk_last = cfg_clk_out;
    repeat (64) @(negedge clk) begin
      ticks += cfg_clk_tick;
      edges += cfg_clk_out ^ clk_last;
      clk_last = cfg_clk_out;
    end
    check("ticks", ticks != 0,
      m != 3'h0 && !(m == 3'h6 && parallel_select_n));
    check("clk out", edges != 0, is_master(m));
    if (err) begin
      @(posedge clk) load_error <= 1'b1;
      @(posedge clk) load_error <= 1'b0;
      load_ok <= 1'b1;
      @(posedge clk) load_ok <= 1'b0;
      repeat (3) @(negedge clk);
      check("held", done_oe_n, 1'b0);
      check("failed", config_fail, 1'b1);
      @(posedge clk) config_reset_n <= 1'b0;
      wait_phase(`ST_CLEAR);
      check("clear", config_clear, 1'b1);
      @(posedge clk) config_reset_n <= 1'b1;
      wait_phase(`ST_LOAD);
      check("start", config_start, 1'b1);
    end
    @(posedge clk) load_ok <= 1'b1;
    @(posedge clk) load_ok <= 1'b0;
    wait_phase(`ST_WAKE);
    check("release", done_oe_n, 1'b1);
    if (hold_it) begin
      repeat (10) @(negedge clk);
      check("stall", wakeup_stall, 1'b1);
      check("waking", phase, `ST_WAKE);
      @(posedge clk) hold <= 1'b0;
    end
    wait_phase(`ST_USER);
    check("done", config_complete, 1'b1);
    check("mux", mux_pins_released, 1'b1);
    check("select off", flash_select_oe_n, 1'b1);
    // Pin pulls follow the state one edge later
    @(negedge clk);
    check("pin pull", cfg_clk_pull_en, post_cfg_pullup);
    check("user pulls", user_pullup_en, 1'b0);
  endtask
  initial begin
    for (int i = 0; i < 14; i++) run(3'(i % 7), i > 6 && i[0], i > 6 && !i[0]);
    run(`MODE_SLV_PAR, 1'b1, 1'b1);
    final_report;
  end
endmodule // config_pin_control_bench
